//--- rtcdc_chain.sv
`timescale 1ns/10ps
// Function
// - chain input clock selectable among internal sources and external pins
// - optional divide-by-32 and divide-by-8 prescalers, each bypassable
// - reloadable 16-bit prescale timer follows the prescalers
// - 32-bit time counter from cascaded 10,6,6,10-bit reloadable sub-timers
// - every timer counts upward only
// - each timer stage can raise its own interrupt request
// - all stage requests merged onto one shared request output
// - power reset clears every chain register except the pin sync flops
module rtcdc_chain import rtcdc_pkg::*; (
	// clock and power reset
	input wire logic clock,
	input wire logic rst_n,
	// clock sources: internal ticks (same domain) and external pins
	input wire logic [1:0] int_tick,
	input wire logic [1:0] ext_pin,
	// control and writes
	input wire rtcdc_ctrl_t ctrl,
	input wire rtcdc_wr_t wr,
	// state
	output logic [15:0] prescale_timer,
	output logic [15:0] time_count_high_word,
	output logic [15:0] time_count_low_word,
	output logic [4:0] stage_irq,
	output logic irq
);
	logic [1:0] pin_s1, pin_s2, pin_s3;
	logic [4:0] pre32_cnt, next_pre32_cnt;
	logic [2:0] pre8_cnt, next_pre8_cnt;
	logic [15:0] pt_rld, next_pt_rld, next_pt;
	logic [31:0] tc, next_tc, tc_rld, next_tc_rld;
	logic [4:0] next_stage_irq;
	logic next_irq;
	logic [RTCDC_NUM_SRC-1:0] src_tick;
	logic in_tick, t32, tick8, t8;
	logic pt_ovf;
	logic [3:0] sub_ovf;

	// external pins: two-stage sync, third flop only for edge detect
	always_ff @(posedge clock) begin
		pin_s1 <= ext_pin;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end

	always_comb begin
		src_tick = {pin_s2 & ~pin_s3, int_tick};
		in_tick = src_tick[ctrl.src_sel];
		next_pre32_cnt = pre32_cnt;
		next_pre8_cnt = pre8_cnt;
		t32 = in_tick;
		if (ctrl.pre32_en && in_tick) begin
			next_pre32_cnt = pre32_cnt + 5'h01;
			t32 = (pre32_cnt == 5'(RTCDC_PRE32_DIV - 1));
		end else if (ctrl.pre32_en) begin
			t32 = 1'b0;
		end
		tick8 = t32;
		t8 = tick8;
		if (ctrl.pre8_en && tick8) begin
			next_pre8_cnt = pre8_cnt + 3'h1;
			t8 = (pre8_cnt == 3'(RTCDC_PRE8_DIV - 1));
		end else if (ctrl.pre8_en) begin
			t8 = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pre32_cnt <= RTCDC_PRE_RST;
			pre8_cnt <= RTCDC_PRE8_RST;
		end else begin
			pre32_cnt <= next_pre32_cnt;
			pre8_cnt <= next_pre8_cnt;
		end
	end

	// sub-timer fields of the 32-bit counter
	function automatic logic [31:0] fmask(input int pos, input int w);
		fmask = ((32'h0000_0001 << w) - 32'h0000_0001) << pos;
	endfunction

	always_comb begin
		next_pt = prescale_timer;
		next_pt_rld = pt_rld;
		next_tc = tc;
		next_tc_rld = tc_rld;
		pt_ovf = 1'b0;
		sub_ovf = 4'h0;
		if (ctrl.run && t8) begin
			pt_ovf = (prescale_timer == 16'hffff);
			next_pt = pt_ovf ? pt_rld : prescale_timer + 16'h0001;
		end
		if (pt_ovf) begin
			sub_ovf[0] = ((tc & fmask(RTCDC_S0_POS, RTCDC_S0_W)) == fmask(RTCDC_S0_POS, RTCDC_S0_W));
			sub_ovf[1] = sub_ovf[0] && ((tc & fmask(RTCDC_S1_POS, RTCDC_S1_W)) == fmask(RTCDC_S1_POS, RTCDC_S1_W));
			sub_ovf[2] = sub_ovf[1] && ((tc & fmask(RTCDC_S2_POS, RTCDC_S2_W)) == fmask(RTCDC_S2_POS, RTCDC_S2_W));
			sub_ovf[3] = sub_ovf[2] && ((tc & fmask(RTCDC_S3_POS, RTCDC_S3_W)) == fmask(RTCDC_S3_POS, RTCDC_S3_W));
			next_tc[9:0] = sub_ovf[0] ? tc_rld[9:0] : tc[9:0] + 10'h001;
			if (sub_ovf[0]) begin
				next_tc[15:10] = sub_ovf[1] ? tc_rld[15:10] : tc[15:10] + 6'h01;
			end
			if (sub_ovf[1]) begin
				next_tc[21:16] = sub_ovf[2] ? tc_rld[21:16] : tc[21:16] + 6'h01;
			end
			if (sub_ovf[2]) begin
				next_tc[31:22] = sub_ovf[3] ? tc_rld[31:22] : tc[31:22] + 10'h001;
			end
		end
		// software writes take precedence over counting
		if (wr.pt_wr) begin
			next_pt = wr.data;
		end
		if (wr.pt_rld_wr) begin
			next_pt_rld = wr.data;
		end
		if (wr.tc_high_wr) begin
			next_tc[31:16] = wr.data;
		end
		if (wr.tc_low_wr) begin
			next_tc[15:0] = wr.data;
		end
		if (wr.rld_high_wr) begin
			next_tc_rld[31:16] = wr.data;
		end
		if (wr.rld_low_wr) begin
			next_tc_rld[15:0] = wr.data;
		end
		next_stage_irq = {sub_ovf, pt_ovf} & ctrl.irq_en;
		next_irq = |next_stage_irq;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prescale_timer <= RTCDC_PT_RST;
			pt_rld <= RTCDC_PT_RST;
			tc <= RTCDC_TC_RST;
			tc_rld <= RTCDC_RLD_RST;
			stage_irq <= RTCDC_IRQ_RST;
			irq <= 1'b0;
		end else begin
			prescale_timer <= next_pt;
			pt_rld <= next_pt_rld;
			tc <= next_tc;
			tc_rld <= next_tc_rld;
			stage_irq <= next_stage_irq;
			irq <= next_irq;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			time_count_high_word <= RTCDC_TC_RST[31:16];
			time_count_low_word <= RTCDC_TC_RST[15:0];
		end else begin
			time_count_high_word <= next_tc[31:16];
			time_count_low_word <= next_tc[15:0];
		end
	end
endmodule

//--- rtcdc_chain_props.sv
`timescale 1ns/10ps
module rtcdc_chain_props import rtcdc_pkg::*; (
	// clock, reset, inputs
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] int_tick,
	input wire logic [1:0] ext_pin,
	input wire rtcdc_ctrl_t ctrl,
	input wire rtcdc_wr_t wr,
	// outputs
	input wire logic [15:0] prescale_timer,
	input wire logic [15:0] time_count_high_word,
	input wire logic [15:0] time_count_low_word,
	input wire logic [4:0] stage_irq,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// direct tick into a full prescale timer, no write in the way
	sequence pt_wrap;
		ctrl.run && ctrl.src_sel == 2'h0 && !ctrl.pre32_en && !ctrl.pre8_en && int_tick[0]
			&& prescale_timer == 16'hffff && !wr.pt_wr && !wr.tc_low_wr;
	endsequence
	chk_irq_merge: assert property (irq == |stage_irq) else $error("merge");
	chk_pt_hold: assert property (!ctrl.run && !wr.pt_wr |=> $stable(prescale_timer)) else $error("hold");
	chk_pt_up: assert property (!wr.pt_wr && prescale_timer != 16'hffff |=>
		$stable(prescale_timer) || prescale_timer == $past(prescale_timer) + 16'h0001) else $error("up");
	chk_pt_irq: assert property (pt_wrap |=> stage_irq[0] == $past(ctrl.irq_en[0])) else $error("wrap");
	chk_tc_carry: assert property (pt_wrap ##0 time_count_low_word[9:0] != 10'h3ff |=>
		time_count_low_word == $past(time_count_low_word) + 16'h0001) else $error("carry");
	chk_irq_gate: assert property (ctrl.irq_en == 5'h00 |=> stage_irq == 5'h00) else $error("gate");
	chk_sub_cause: assert property (stage_irq[1] |-> $past(time_count_low_word[9:0]) == 10'h3ff) else $error("sub");
	chk_rst_clear: assert property (disable iff (1'b0) !rst_n |=> prescale_timer == 16'h0000 && irq == 1'b0)
		else $error("rst");
endmodule
bind rtcdc_chain rtcdc_chain_props u_props (.clock(clock), .rst_n(rst_n), .int_tick(int_tick), .ext_pin(ext_pin),
	.ctrl(ctrl), .wr(wr), .prescale_timer(prescale_timer), .time_count_high_word(time_count_high_word),
	.time_count_low_word(time_count_low_word), .stage_irq(stage_irq), .irq(irq));

//--- rtcdc_pkg.sv
package rtcdc_pkg;
	localparam int RTCDC_NUM_SRC = 4;
	localparam int RTCDC_SRC_W = 2;
	localparam int RTCDC_PRE32_DIV = 32;
	localparam int RTCDC_PRE8_DIV = 8;
	localparam int RTCDC_PRE_W = 5;
	localparam int RTCDC_PT_W = 16;
	localparam int RTCDC_S0_W = 10;
	localparam int RTCDC_S1_W = 6;
	localparam int RTCDC_S2_W = 6;
	localparam int RTCDC_S3_W = 10;
	localparam int RTCDC_TC_W = 32;
	localparam int RTCDC_S0_POS = 0;
	localparam int RTCDC_S1_POS = 10;
	localparam int RTCDC_S2_POS = 16;
	localparam int RTCDC_S3_POS = 22;
	localparam int RTCDC_STAGES = 5;
	localparam logic [15:0] RTCDC_PT_RST = 16'h0000;
	localparam logic [31:0] RTCDC_TC_RST = 32'h0000_0000;
	localparam logic [31:0] RTCDC_RLD_RST = 32'h0000_0000;
	localparam logic [4:0] RTCDC_PRE_RST = 5'h00;
	localparam logic [2:0] RTCDC_PRE8_RST = 3'h0;
	localparam logic [4:0] RTCDC_IRQ_RST = 5'h00;

	// control inputs of the chain
	typedef struct packed {
		logic [1:0] src_sel;
		logic pre32_en;
		logic pre8_en;
		logic run;
		logic [4:0] irq_en;
	} rtcdc_ctrl_t;

	// word write strobes into the chain
	typedef struct packed {
		logic pt_wr;
		logic pt_rld_wr;
		logic tc_high_wr;
		logic tc_low_wr;
		logic rld_high_wr;
		logic rld_low_wr;
		logic [15:0] data;
	} rtcdc_wr_t;
endpackage

//--- test_rtcdc_chain.sv
`timescale 1ns/10ps
module test_rtcdc_chain;
	import rtcdc_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] int_tick = 2'h0;
	logic [1:0] ext_pin = 2'h0;
	rtcdc_ctrl_t ctrl = '0;
	rtcdc_wr_t wr = '0;
	logic [15:0] pt, hi, lo;
	logic [4:0] sirq;
	logic irq;
	logic [31:0] q[$];
	logic [31:0] t, e, p;
	logic [4:0] xirq;
	int fails = 0, compares = 0, seed = 47473, n;
	rtcdc_chain u_dut (.clock(clock), .rst_n(rst_n), .int_tick(int_tick), .ext_pin(ext_pin), .ctrl(ctrl), .wr(wr),
		.prescale_timer(pt), .time_count_high_word(hi), .time_count_low_word(lo), .stage_irq(sirq), .irq(irq));
	initial begin
		forever #4 clock = ~clock;
	end
	task close_out;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task check_tc(input logic [31:0] x, input logic [31:0] s);
		compares++;
		if (x !== s) begin
			fails++;
			$display("ERROR time_count exp %h got %h", x, s);
		end
	endtask
	task check_irq(input logic [4:0] x, input logic [4:0] s);
		compares++;
		if (x !== s) begin
			fails++;
			$display("ERROR stage_irq exp %h got %h", x, s);
		end
	endtask
	task check_pt(input logic [15:0] x, input logic [15:0] s);
		compares++;
		if (x !== s) begin
			fails++;
			$display("ERROR prescale_timer exp %h got %h", x, s);
		end
	endtask
	// one-cycle write strobe k with data d
	task w(input logic [5:0] k, input logic [15:0] d);
		@(posedge clock) wr <= {k, d};
		@(posedge clock) wr <= '0;
	endtask
	always @(negedge clock) begin
		if (irq === 1'b1) begin
			t = q.size() > 0 ? q.pop_front() : 32'hxxxx_xxxx;
			check_tc(t, {hi, lo});
			// value before the tick decides which sub-timers wrapped
			p = t - 32'h0000_0001;
			xirq[0] = 1'b1;
			xirq[1] = &p[9:0];
			xirq[2] = xirq[1] & (&p[15:10]);
			xirq[3] = xirq[2] & (&p[21:16]);
			xirq[4] = xirq[3] & (&p[31:22]);
			check_irq(xirq, sirq);
			check_pt(16'hfffe, pt);
		end
	end
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		ctrl.irq_en <= 5'h1f;
		w(6'h10, 16'hfffe);
		// source c, prescalers {32,8} = c
		for (int c = 0; c < 4; c++) begin
			e[31:16] = $random(seed);
			e[15:0] = $random(seed);
			w(6'h20, 16'hfffe);
			w(6'h08, e[31:16]);
			w(6'h04, e[15:0]);
			for (int k = 1; k < 5; k++)
				q.push_back(e + k);
			ctrl.src_sel <= c[1:0];
			{ctrl.pre32_en, ctrl.pre8_en} <= c[1:0];
			ctrl.run <= 1'b1;
			int_tick <= 2'h3;
			for (n = 0; n < 10000 && q.size() > 0; n++) begin
				@(posedge clock);
				ext_pin <= {2{n[1]}};
			end
			ctrl.run <= 1'b0;
			if (q.size() > 0) begin
				fails++;
				close_out;
			end
			$display("test %0d done", c);
		end
		close_out;
	end
endmodule
